// ==== verilog/pid_pkg.sv ====
// Summary of operation
// - methods 1,2 drive frequency directly; methods 3,4 add output to reference.
// - methods 1,3 differentiate the error; methods 2,4 differentiate feedback only.
// - by default the setpoint follows the selected frequency reference source.
// - analog input two function code C makes that input the setpoint.
// - control register bit 1 set makes register COMM_PID_SETPOINT the setpoint.
// - pulse input code 0 reference, code 1 feedback, code 2 setpoint.
// - setpoint source select 1 uses the stored setpoint value.
// - hertz setpoints convert to percent: value / max frequency * 100%.
// - a nonzero monitor feedback select uses the chosen monitor item as feedback.
// - the accumulated integral is clamped to the integral limit.
// - regulator output is clamped to the output limit, max frequency = 100%.
// - a signed offset in 0.1% steps is added to the output.
// - output passes a first-order lag; larger time constant responds slower.
// - polarity select inverts the regulator output.
// - output is multiplied by a gain, sizing the methods 3,4 correction.
// - negative output handled by selector; reverse prohibit clamps it to zero.
// - setpoint changes are ramped by a soft starter with configurable time.
// - the normal accel/decel ramp sits after the regulator output.
// - digital input function 34 bypasses the soft starter while active.
// - loss mode 1: feedback low longer than loss time raises an alarm.
// - loss mode 2: same condition faults, coasts the motor, closes contact.
// - loss time defaults to 1.0 s and loss level to 0%.
// - digital function 31 holds the integral, function 30 resets it.
package pid_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int UPDATE_PERIOD_NS = 1000000;
    localparam int UPDATE_CYCLES = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOSS_TICK_NS = 100000000;
    localparam int LOSS_TICK_CYCLES = LOSS_TICK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] LOSS_TIME_TENTHS = 8'h0A;
    localparam logic signed [15:0] LOSS_LEVEL = 16'sh0000;
    localparam int NUM_DIN = 5;
    localparam logic [15:0] REG_SETPOINT_ADDR = 16'h0006;
    localparam logic [15:0] REG_CONTROL_ADDR = 16'h000F;
    localparam int SETPOINT_ENABLE_BIT = 1;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] FULL_SCALE = 16'h03E8;
    localparam int GAIN_SHIFT = 8;
    localparam logic [3:0] AIN2_FEEDBACK = 4'hB;
    localparam logic [3:0] AIN2_SETPOINT = 4'hC;
    localparam logic [1:0] PULSE_REFERENCE = 2'h0;
    localparam logic [1:0] PULSE_FEEDBACK = 2'h1;
    localparam logic [1:0] PULSE_SETPOINT = 2'h2;
    localparam logic [1:0] REF_SRC_ANALOG = 2'h1;
    localparam logic [1:0] REF_SRC_PULSE = 2'h2;
    localparam logic [7:0] FN_INTEGRAL_RESET = 8'h1E;
    localparam logic [7:0] FN_INTEGRAL_HOLD = 8'h1F;
    localparam logic [7:0] FN_SOFT_START_OFF = 8'h22;
    localparam logic [2:0] METHOD_DIRECT_ERR = 3'h1;
    localparam logic [2:0] METHOD_DIRECT_FB = 3'h2;
    localparam logic [2:0] METHOD_ADD_ERR = 3'h3;
    localparam logic [2:0] METHOD_ADD_FB = 3'h4;
    localparam logic [1:0] LOSS_MODE_ALARM = 2'h1;
    localparam logic [1:0] LOSS_MODE_FAULT = 2'h2;
    typedef enum logic [1:0] {
        LOSS_IDLE = 2'b00,
        LOSS_TIMING = 2'b01,
        LOSS_ALARM = 2'b10,
        LOSS_FAULT = 2'b11
    } loss_state_t;
endpackage

// ==== verilog/setpoint_ramp.sv ====
`timescale 1ns/1ns
module setpoint_ramp #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tick,
    input wire logic bypass,
    input wire logic [15:0] stepPeriod,
    input wire logic signed [W-1:0] target,
    output logic signed [W-1:0] value
);
    logic [15:0] waitCount;
    wire stepDue = waitCount == stepPeriod - 16'h0001;
    wire signed [W-1:0] oneStep = (target > value) ? W'(1) : W'(-1);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value <= '0;
            waitCount <= 16'h0000;
        end else if (ce) begin
            if (bypass) begin
                value <= target;
                waitCount <= 16'h0000;
            end else if (tick && value != target) begin
                // one lsb per stepPeriod updates keeps the ramp free of dividers
                waitCount <= stepDue ? 16'h0000 : waitCount + 16'h0001;
                if (stepDue) begin
                    value <= value + oneStep;
                end
            end
        end
    end

    bypass_follow_a: assert property (@(posedge clk) disable iff (reset)
        (ce && bypass) |=> value == $past(target))
        else $error("soft starter bypass did not follow target");
    ramp_step_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !bypass) |=> (value - $past(value) <= 1) && ($past(value) - value <= 1))
        else $error("soft starter moved more than one step");
endmodule

// ==== verilog/first_order_filter.sv ====
`timescale 1ns/1ns
module first_order_filter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tick,
    input wire logic [3:0] shift,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    // 16 fraction bits so long time constants still creep toward x
    logic signed [W+15:0] acc;
    wire signed [W+16:0] xs = {x[W-1], x, 16'h0000};
    wire signed [W+16:0] diff = xs - {acc[W+15], acc};
    wire signed [W+16:0] stepv = diff >>> shift;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc <= '0;
        end else if (ce && tick) begin
            acc <= acc + stepv[W+15:0];
        end
    end

    assign y = acc[W+15:16];

    filter_pass_a: assert property (@(posedge clk) disable iff (reset)
        (ce && tick && shift == 4'h0) |=> y == $past(x))
        else $error("zero time constant filter did not pass input");
endmodule

// ==== verilog/pid_process_regulator.sv ====
`timescale 1ns/1ns
module pid_process_regulator #(
    parameter int UPDATE_CYCLES = pid_pkg::UPDATE_CYCLES,
    parameter int LOSS_TICK_CYCLES = pid_pkg::LOSS_TICK_CYCLES,
    parameter logic [7:0] LOSS_TIME_TENTHS = pid_pkg::LOSS_TIME_TENTHS,
    parameter logic signed [15:0] LOSS_LEVEL = pid_pkg::LOSS_LEVEL,
    parameter int NUM_DIN = pid_pkg::NUM_DIN
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    input wire logic [2:0] regulatorMethodSelect,
    input wire logic [15:0] propGain,
    input wire logic [15:0] integralGain,
    input wire logic [15:0] derivGain,
    input wire logic [15:0] integralLimit,
    input wire logic [15:0] regulatorOutputLimit,
    input wire logic signed [15:0] regulatorOffset,
    input wire logic [3:0] outputFilterTime,
    input wire logic outputPolaritySelect,
    input wire logic [15:0] outputGain,
    input wire logic negativeOutputSelect,
    input wire logic [1:0] feedbackLossMode,
    input wire logic [15:0] setpointRampTime,
    input wire logic setpointSourceSelect,
    input wire logic signed [15:0] storedSetpoint,
    input wire logic [7:0] monitorFeedbackSelect,
    input wire logic [1:0] referenceSourceSelect,
    input wire logic reverseProhibit,
    input wire logic [3:0] analogIn2Function,
    input wire logic [1:0] pulseInFunction,
    input wire logic [NUM_DIN*8-1:0] digitalInputFunction,
    input wire logic [NUM_DIN-1:0] digitalInputs,
    input wire logic faultReset,
    input wire logic [15:0] operatorRefHz,
    input wire logic [15:0] maxOutputFreqHz,
    input wire logic signed [15:0] analogIn1,
    input wire logic signed [15:0] analogInputTwo,
    input wire logic signed [15:0] pulseIn,
    input wire logic signed [15:0] monitorItem,
    output logic signed [15:0] freqCommand,
    output logic signed [15:0] regulatorOut,
    output logic signed [15:0] setpointNow,
    output logic feedbackLossAlarm,
    output logic feedbackLossFault,
    output logic driveCoast,
    output logic faultContact
);
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sh0000_7FFF) begin
            return 16'sh7FFF;
        end else if (v < 32'shFFFF_8000) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    // ************************************************************
    // serial registers
    // ************************************************************
    logic signed [15:0] commSetpoint;
    logic [15:0] commControl;
    wire selSetpoint = regAddr == pid_pkg::REG_SETPOINT_ADDR;
    wire selControl = regAddr == pid_pkg::REG_CONTROL_ADDR;
    wire [15:0] readMux = selSetpoint ? commSetpoint : selControl ? commControl : 16'h0000;
    wire commEnable = commControl[pid_pkg::SETPOINT_ENABLE_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            commSetpoint <= pid_pkg::REG_RESET;
            commControl <= pid_pkg::REG_RESET;
            regRdata <= 16'h0000;
        end else if (ce) begin
            regRdata <= readMux;
            if (regWrite && selSetpoint) begin
                commSetpoint <= regWdata;
            end
            if (regWrite && selControl) begin
                commControl <= regWdata;
            end
        end
    end

    // ************************************************************
    // source selection
    // ************************************************************
    wire [31:0] hzScaled = {16'h0000, operatorRefHz} * {16'h0000, pid_pkg::FULL_SCALE};
    wire maxIsZero = maxOutputFreqHz == 16'h0000;
    // divide by zero guarded: no max frequency means no reference
    wire [31:0] hzQuot = maxIsZero ? 32'h0000_0000 : hzScaled / {16'h0000, maxOutputFreqHz};
    wire signed [15:0] hzPercent = sat16($signed(hzQuot & 32'h7FFF_FFFF));
    wire pulseIsRef = pulseInFunction == pid_pkg::PULSE_REFERENCE;
    wire pulseIsFb = pulseInFunction == pid_pkg::PULSE_FEEDBACK;
    wire pulseIsSp = pulseInFunction == pid_pkg::PULSE_SETPOINT;
    wire refAnalog = referenceSourceSelect == pid_pkg::REF_SRC_ANALOG;
    wire refPulse = referenceSourceSelect == pid_pkg::REF_SRC_PULSE && pulseIsRef;
    wire signed [15:0] refPercent = refAnalog ? analogIn1 : refPulse ? pulseIn : hzPercent;
    wire ain2Sp = analogIn2Function == pid_pkg::AIN2_SETPOINT;
    wire ain2Fb = analogIn2Function == pid_pkg::AIN2_FEEDBACK;
    wire signed [15:0] rawSetpoint = commEnable ? commSetpoint :
        setpointSourceSelect ? storedSetpoint :
        ain2Sp ? analogInputTwo :
        pulseIsSp ? pulseIn : refPercent;
    wire monitorOn = monitorFeedbackSelect != 8'h00;
    wire signed [15:0] feedbackValue = pulseIsFb ? pulseIn :
        ain2Fb ? analogInputTwo :
        monitorOn ? monitorItem : analogIn1;

    // ************************************************************
    // digital input functions
    // ************************************************************
    logic [NUM_DIN-1:0] dinReset;
    logic [NUM_DIN-1:0] dinHold;
    logic [NUM_DIN-1:0] dinSoftOff;
    for (genvar g = 0; g < NUM_DIN; g++) begin : g_din
        wire [7:0] fn = digitalInputFunction[g*8 +: 8];
        assign dinReset[g] = digitalInputs[g] && fn == pid_pkg::FN_INTEGRAL_RESET;
        assign dinHold[g] = digitalInputs[g] && fn == pid_pkg::FN_INTEGRAL_HOLD;
        assign dinSoftOff[g] = digitalInputs[g] && fn == pid_pkg::FN_SOFT_START_OFF;
    end
    wire intReset = |dinReset;
    wire intHold = |dinHold;
    wire softOff = |dinSoftOff;

    // ************************************************************
    // update period and soft starter
    // ************************************************************
    logic [31:0] updCount;
    wire tick = ce && (updCount == 32'(UPDATE_CYCLES - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            updCount <= 32'h0000_0000;
        end else if (ce) begin
            updCount <= tick ? 32'h0000_0000 : updCount + 32'h0000_0001;
        end
    end

    setpoint_ramp #(.W(16)) u_ramp (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .tick(tick),
        .bypass(softOff || setpointRampTime == 16'h0000),
        .stepPeriod(setpointRampTime),
        .target(rawSetpoint),
        .value(setpointNow)
    );

    // ************************************************************
    // regulator core
    // ************************************************************
    logic signed [31:0] integ;
    logic signed [31:0] prevDeriv;
    wire methodAdd = regulatorMethodSelect == pid_pkg::METHOD_ADD_ERR ||
        regulatorMethodSelect == pid_pkg::METHOD_ADD_FB;
    wire methodDirect = regulatorMethodSelect == pid_pkg::METHOD_DIRECT_ERR ||
        regulatorMethodSelect == pid_pkg::METHOD_DIRECT_FB;
    wire derivOnFb = regulatorMethodSelect == pid_pkg::METHOD_DIRECT_FB ||
        regulatorMethodSelect == pid_pkg::METHOD_ADD_FB;
    wire signed [31:0] errorNow = 32'(setpointNow) - 32'(feedbackValue);
    wire signed [31:0] derivIn = derivOnFb ? -32'(feedbackValue) : errorNow;
    wire signed [31:0] derivDiff = derivIn - prevDeriv;
    wire signed [47:0] pProd = 48'(errorNow) * $signed({32'h0000_0000, propGain});
    wire signed [47:0] iProd = 48'(errorNow) * $signed({32'h0000_0000, integralGain});
    wire signed [47:0] dProd = 48'(derivDiff) * $signed({32'h0000_0000, derivGain});
    wire signed [31:0] pTerm = 32'(pProd >>> pid_pkg::GAIN_SHIFT);
    wire signed [31:0] iStep = 32'(iProd >>> pid_pkg::GAIN_SHIFT);
    wire signed [31:0] dTerm = 32'(dProd >>> pid_pkg::GAIN_SHIFT);
    wire signed [31:0] intLimit = $signed({16'h0000, integralLimit});
    wire signed [31:0] intSum = integ + iStep;
    wire signed [31:0] intClamped = (intSum > intLimit) ? intLimit :
        (intSum < -intLimit) ? -intLimit : intSum;
    wire signed [31:0] sumAll = pTerm + intClamped + dTerm;
    wire signed [31:0] outLimit = $signed({16'h0000, regulatorOutputLimit});
    wire signed [31:0] limited = (sumAll > outLimit) ? outLimit :
        (sumAll < -outLimit) ? -outLimit : sumAll;
    wire signed [31:0] offsetApplied = limited + 32'(regulatorOffset);
    wire signed [31:0] polarized = outputPolaritySelect ? -offsetApplied : offsetApplied;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            integ <= 32'sh0000_0000;
            prevDeriv <= 32'sh0000_0000;
            regulatorOut <= 16'sh0000;
        end else if (ce) begin
            if (intReset) begin
                integ <= 32'sh0000_0000;
            end else if (tick && !intHold) begin
                integ <= intClamped;
            end
            if (tick) begin
                prevDeriv <= derivIn;
                regulatorOut <= sat16(polarized);
            end
        end
    end

    // ************************************************************
    // output stage
    // ************************************************************
    logic signed [15:0] filtered;
    first_order_filter #(.W(16)) u_filter (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .tick(tick),
        .shift(outputFilterTime),
        .x(regulatorOut),
        .y(filtered)
    );

    wire signed [47:0] gainProd = 48'(filtered) * $signed({32'h0000_0000, outputGain});
    wire signed [31:0] gained = 32'(gainProd >>> pid_pkg::GAIN_SHIFT);
    // with the regulator disabled the reference passes untouched
    wire signed [31:0] combined = methodAdd ? 32'(refPercent) + gained :
        methodDirect ? gained : 32'(refPercent);
    wire negClamp = combined < 0 && (reverseProhibit || !negativeOutputSelect);
    wire signed [31:0] finalOut = (feedbackLossFault || negClamp) ? 32'sh0000_0000 : combined;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            freqCommand <= 16'sh0000;
        end else if (ce) begin
            // feeds the drive's own accel/decel ramp, which sits downstream
            freqCommand <= sat16(finalOut);
        end
    end

    // ************************************************************
    // feedback loss detection
    // ************************************************************
    pid_pkg::loss_state_t lossState;
    pid_pkg::loss_state_t next_lossState;
    logic [31:0] lossCycles;
    logic [7:0] lossTenths;
    wire feedbackLow = feedbackValue < LOSS_LEVEL;
    wire modeFault = feedbackLossMode == pid_pkg::LOSS_MODE_FAULT;
    wire lossModeOn = feedbackLossMode == pid_pkg::LOSS_MODE_ALARM || modeFault;
    wire tenthTick = lossCycles == 32'(LOSS_TICK_CYCLES - 1);
    wire lossExpired = tenthTick && lossTenths == LOSS_TIME_TENTHS - 8'h01;
    wire lossTiming = lossState == pid_pkg::LOSS_TIMING;

    always_comb begin
        next_lossState = lossState;
        case (lossState)
            pid_pkg::LOSS_IDLE: begin
                if (lossModeOn && feedbackLow) begin
                    next_lossState = pid_pkg::LOSS_TIMING;
                end
            end
            pid_pkg::LOSS_TIMING: begin
                if (!lossModeOn || !feedbackLow) begin
                    next_lossState = pid_pkg::LOSS_IDLE;
                end else if (lossExpired) begin
                    next_lossState = modeFault ? pid_pkg::LOSS_FAULT : pid_pkg::LOSS_ALARM;
                end
            end
            pid_pkg::LOSS_ALARM: begin
                if (!lossModeOn || !feedbackLow) begin
                    next_lossState = pid_pkg::LOSS_IDLE;
                end
            end
            pid_pkg::LOSS_FAULT: begin
                // latched until reset by the operator once feedback recovers
                if (faultReset && !feedbackLow) begin
                    next_lossState = pid_pkg::LOSS_IDLE;
                end
            end
            default: next_lossState = pid_pkg::LOSS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lossState <= pid_pkg::LOSS_IDLE;
            lossCycles <= 32'h0000_0000;
            lossTenths <= 8'h00;
        end else if (ce) begin
            lossState <= next_lossState;
            lossCycles <= (!lossTiming || tenthTick) ? 32'h0000_0000 : lossCycles + 32'h0000_0001;
            if (!lossTiming) begin
                lossTenths <= 8'h00;
            end else if (tenthTick) begin
                lossTenths <= lossTenths + 8'h01;
            end
        end
    end

    assign feedbackLossAlarm = lossState == pid_pkg::LOSS_ALARM;
    assign feedbackLossFault = lossState == pid_pkg::LOSS_FAULT;
    assign driveCoast = feedbackLossFault;
    assign faultContact = feedbackLossFault;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    alarm_needs_mode_a: assert property ($rose(feedbackLossAlarm) |->
        $past(feedbackLossMode) == pid_pkg::LOSS_MODE_ALARM &&
        $past(lossTenths) == LOSS_TIME_TENTHS - 8'h01)
        else $error("loss alarm raised without mode 1 or full time");
    fault_stops_drive_a: assert property ((ce && feedbackLossFault) |=>
        freqCommand == 16'sh0000)
        else $error("frequency not zero during loss fault");
    integ_clamp_a: assert property ((tick && !intHold && !intReset) |=>
        integ <= $signed({16'h0000, $past(integralLimit)}) &&
        integ >= -$signed({16'h0000, $past(integralLimit)}))
        else $error("integral exceeded its limit");
    integ_reset_a: assert property ((ce && intReset) |=> integ == 32'sh0000_0000)
        else $error("integral not cleared by reset input");
    integ_hold_a: assert property ((ce && intHold && !intReset) |=> $stable(integ))
        else $error("integral changed while held");
    out_limit_a: assert property ((tick && regulatorOffset == 16'sh0000) |=>
        regulatorOut <= $signed({16'h0000, $past(regulatorOutputLimit)}) &&
        regulatorOut >= -$signed({16'h0000, $past(regulatorOutputLimit)}))
        else $error("regulator output exceeded output limit");
    reverse_clamp_a: assert property ((ce && reverseProhibit) |=> freqCommand >= 16'sh0000)
        else $error("negative frequency while reverse prohibited");
    direct_method_a: assert property ((ce && methodDirect && !feedbackLossFault &&
        gained >= 0 && gained <= 32'sh0000_7FFF) |=> 32'(freqCommand) == $past(gained))
        else $error("direct method output does not follow regulator");
    comm_setpoint_a: assert property ((ce && commEnable && setpointRampTime == 16'h0000)
        |=> setpointNow == $past(commSetpoint))
        else $error("register setpoint not selected");

    alarm_seen_c: cover property ($rose(feedbackLossAlarm));
    fault_seen_c: cover property ($rose(feedbackLossFault));
    integ_clamped_c: cover property (tick && intSum > intLimit);
    add_method_c: cover property (ce && methodAdd && gained != 32'sh0000_0000);
endmodule

// ==== tb/feedback_sensor.sv ====
`timescale 1ns/1ns
// ************
// sensor model
// ************
module feedback_sensor (
    input wire logic clk,
    input wire logic lost,
    input wire logic signed [15:0] level,
    output logic signed [15:0] pulseIn,
    output logic signed [15:0] monitorItem
);
    // a broken sensor reads below zero at pulseIn, not a held value; monitorItem carries its bitwise inverse
    always_ff @(posedge clk) begin
        pulseIn <= lost ? -16'sh0032 : level;
        monitorItem <= ~pulseIn;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
logic clk=0, reset=1, ce=1, regWrite=0, outputPolaritySelect=0, negativeOutputSelect=1;
logic setpointSourceSelect=0, reverseProhibit=0, faultReset=0, lost=0;
logic [15:0] regAddr=0, regWdata=0, regRdata, propGain=0, integralGain=0, derivGain=0, r;
logic [15:0] integralLimit=16'h03E8, regulatorOutputLimit=16'h03E8, outputGain=16'h0100;
logic [15:0] setpointRampTime=0, operatorRefHz=16'h001E, maxOutputFreqHz=16'h003C, e;
logic [2:0] regulatorMethodSelect=3'h1, s;
logic [1:0] feedbackLossMode=0, referenceSourceSelect=0, pulseInFunction=2'h1;
logic [3:0] outputFilterTime=0, analogIn2Function=0;
logic [7:0] monitorFeedbackSelect=0;
logic [39:0] digitalInputFunction=0;
logic [4:0] digitalInputs=0;
logic signed [15:0] regulatorOffset=0, storedSetpoint=0, analogIn1=0, analogInputTwo=0;
logic signed [15:0] pulseIn, monitorItem, freqCommand, regulatorOut, setpointNow;
logic feedbackLossAlarm, feedbackLossFault, driveCoast, faultContact;
int fails=0, checked=0;
logic [15:0] q[$];
logic [2:0] qs[$];
event ev;
pid_process_regulator #(.UPDATE_CYCLES(4), .LOSS_TICK_CYCLES(4)) dut (.*);
feedback_sensor fb (.clk(clk), .lost(lost), .level(analogIn1), .pulseIn(pulseIn),
    .monitorItem(monitorItem));
initial forever #10 clk = ~clk;
// *****
// tasks
// *****
task step(input int n, input logic [2:0] k, input logic [15:0] x);
    repeat (n) @(posedge clk);
    qs.push_back(k);
    q.push_back(x);
    ->ev;
endtask
task wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a; regWdata <= d; regWrite <= 1;
    @(posedge clk);
    regWrite <= 0;
endtask
task rdreg(input logic [15:0] a, input logic [15:0] x);
    @(posedge clk);
    regAddr <= a;
    step(2, 0, x);
endtask
task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
        fails++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task cmpReg(input logic [15:0] x);
    cmp(regRdata, x);
endtask
task cmpFreq(input logic [15:0] x);
    cmp(freqCommand, x);
endtask
task cmpSet(input logic [15:0] x);
    cmp(setpointNow, x);
endtask
task cmpOut(input logic [15:0] x);
    cmp(regulatorOut, x);
endtask
task cmpLoss(input logic [15:0] x);
    cmp({12'h000, feedbackLossAlarm, feedbackLossFault, driveCoast, faultContact}, x);
endtask
task summarize;
    $display("compares=%0d mismatches=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
// ***************
// result watcher
// ***************
initial forever begin
    @(ev);
    #1;
    while (q.size() > 0) begin
        s = qs.pop_front();
        e = q.pop_front();
        case (s)
            3'h0: cmpReg(e);
            3'h1: cmpFreq(e);
            3'h2: cmpSet(e);
            3'h4: cmpOut(e);
            default: cmpLoss(e);
        endcase
    end
end
initial begin
    #200000;
    fails++;
    summarize;
end
// *****
// tests
// *****
initial begin
    r = 16'($urandom(67) % 1000);
    repeat (8) @(posedge clk);
    reset <= 0;
    wreg(16'h000F, 16'h0002);
    wreg(16'h0006, 16'h0123);
    rdreg(16'h000F, 16'h0002);
    rdreg(16'h0020, 16'h0000);
    step(3, 2, 16'h0123);
    wreg(16'h000F, 16'h0000);
    setpointSourceSelect <= 1; storedSetpoint <= r;
    step(4, 2, r);
    setpointSourceSelect <= 0; analogIn2Function <= 4'hC; analogInputTwo <= 16'sh012C;
    step(4, 2, 16'h012C);
    analogIn2Function <= 0; pulseInFunction <= 2'h2; analogIn1 <= 16'sh00C8;
    step(4, 2, 16'h00C8);
    pulseInFunction <= 2'h1;
    step(4, 2, 16'h01F4);
    referenceSourceSelect <= 2'h1;
    step(4, 2, 16'h00C8);
    $display("setpoint test done");
    analogIn1 <= 0; regulatorOffset <= 16'sh0064;
    step(20, 1, 16'h0064);
    outputPolaritySelect <= 1;
    step(20, 1, 16'hFF9C);
    reverseProhibit <= 1;
    step(20, 1, 16'h0000);
    $display("output test done");
    reverseProhibit <= 0; outputPolaritySelect <= 0; feedbackLossMode <= 2'h1; lost <= 1;
    step(20, 3, 16'h0000);
    step(40, 3, 16'h0008);
    lost <= 0;
    step(4, 3, 16'h0000);
    feedbackLossMode <= 2'h2; lost <= 1;
    step(60, 3, 16'h0007);
    step(1, 1, 16'h0000);
    lost <= 0; faultReset <= 1;
    step(4, 3, 16'h0000);
    $display("loss test done");
    feedbackLossMode <= 0; faultReset <= 0; regulatorOffset <= 0; propGain <= 16'h0100;
    integralGain <= 16'h0100; integralLimit <= 16'h012C; regulatorOutputLimit <= 16'h0190;
    regulatorMethodSelect <= 3'h3; outputGain <= 16'h0080; referenceSourceSelect <= 0;
    setpointSourceSelect <= 1; storedSetpoint <= 16'sh00C8;
    step(20, 4, 16'h0190);
    step(1, 1, 16'h02BC);
    propGain <= 0; digitalInputFunction <= 40'h00_0022_1F1E; digitalInputs <= 5'h01;
    step(12, 4, 16'h00C8);
    digitalInputs <= 5'h02;
    step(12, 4, 16'h00C8);
    digitalInputs <= 0;
    step(16, 4, 16'h012C);
    setpointRampTime <= 16'h0100; storedSetpoint <= 16'sh012C;
    step(8, 2, 16'h00C8);
    digitalInputs <= 5'h04;
    step(2, 2, 16'h012C);
    digitalInputs <= 5'h01; setpointRampTime <= 0; integralGain <= 0; propGain <= 16'h0100;
    pulseInFunction <= 0; analogIn2Function <= 4'hB; analogInputTwo <= 16'sh0064;
    step(12, 4, 16'h00C8);
    analogIn2Function <= 0; monitorFeedbackSelect <= 8'h01;
    step(12, 4, 16'h012D);
    ce <= 0; monitorFeedbackSelect <= 0;
    step(12, 4, 16'h012D);
    ce <= 1;
    step(12, 4, 16'h012C);
    $display("regulator test done");
    summarize;
end
endmodule
